/* File: tao_exec.sv */
// How it works
// RULE1 - Test sets N, Z, clears V only
// RULE2 - Memory test forms take fixed cycle counts
// RULE3 - Offset or direct byte follows the opcode
// RULE4 - Opcode 95 loads index pair with SP+1
// RULE5 - Opcode 9F copies index low into accumulator
// RULE6 - Opcode 94 loads SP with index pair-1
// RULE7 - Prefix 9E selects stack relative map
`timescale 1ns/10ps
module tao_exec import tao_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Program byte stream
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    output logic byte_take,
    // Operand read path, data answers in the same cycle
    output logic mem_rd,
    output logic [15:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    // Core registers
    input wire tao_regs_t regs_in,
    output tao_wr_t wr_out,
    // Instruction status
    output logic done,
    output logic illegal
);

    // One state per bus cycle of an instruction
    typedef enum logic [2:0] {
        ST_OPCODE,
        ST_PFX_OP,
        ST_OFFSET,
        ST_READ,
        ST_XFER
    } tao_state_t;

    // Opcode decode, shared by the plain and prefixed opcode cycles
    function automatic tao_kind_t tao_decode(input logic [7:0] op, input logic pfx);
        tao_kind_t k;
        k = K_ILLEGAL;
        if (pfx) begin
            if (op == OPC_PFX_TEST_SP1) begin
                k = K_TEST_SP1; // [RULE7]
            end
        end else begin
            unique case (op)
                OPC_TEST_DIR: k = K_TEST_DIR; // [RULE2]
                OPC_TEST_ACCUM: k = K_TEST_ACCUM; // [RULE1]
                OPC_TEST_INDEX_LOW: k = K_TEST_INDEX_LOW; // [RULE1]
                OPC_TEST_IX1: k = K_TEST_IX1; // [RULE2]
                OPC_TEST_IX: k = K_TEST_IX; // [RULE2]
                OPC_INDEX_PAIR_TO_SP: k = K_INDEX_PAIR_TO_SP; // [RULE6]
                OPC_SP_TO_INDEX_PAIR: k = K_SP_TO_INDEX_PAIR; // [RULE4]
                OPC_INDEX_LOW_TO_ACCUM: k = K_INDEX_LOW_TO_ACCUM; // [RULE5]
                OPC_PREFIX: k = K_PREFIX; // [RULE7]
                default: k = K_ILLEGAL;
            endcase
        end
        return k;
    endfunction

    // Register test forms take their operand straight from the core
    function automatic logic is_reg_test(input tao_kind_t k);
        return (k == K_TEST_ACCUM) || (k == K_TEST_INDEX_LOW);
    endfunction

    // Registered sequencer state, write-back and status
    tao_state_t state_q, state_d;
    tao_kind_t kind_q, kind_d;
    logic [15:0] addr_q, addr_d;
    tao_wr_t wr_q, wr_d;
    logic done_q, done_d;
    logic illegal_q, illegal_d;

    // Decode and operand selection
    wire in_opcode = (state_q == ST_OPCODE) || (state_q == ST_PFX_OP);
    wire tao_kind_t kind_now = tao_decode(byte_data, state_q == ST_PFX_OP);
    wire op_fire = in_opcode && byte_valid;
    wire reg_test_now = is_reg_test(kind_now);
    wire [7:0] flag_src = (state_q == ST_READ) ? mem_rdata :
                          (kind_now == K_TEST_ACCUM) ? regs_in.accum :
                          regs_in.index_pair[7:0];
    wire [15:0] offset_word = {ZERO_BYTE, byte_data};
    wire [15:0] sp_plus_one = regs_in.stack_ptr + ONE_WORD;
    wire [15:0] hx_minus_one = regs_in.index_pair - ONE_WORD;
    wire [7:0] ccr_tested;

    // Effective addresses; unsigned 8-bit offsets wrap at 64K, no carry out
    wire [15:0] dir_addr = offset_word; // [RULE3]
    wire [15:0] ix1_addr = regs_in.index_pair + offset_word; // [RULE3]
    wire [15:0] sp1_addr = regs_in.stack_ptr + offset_word; // [RULE3] [RULE7]

    // Single flag unit serves register and memory forms
    tao_flag_unit u_flags (
        .ccr_in(regs_in.cond_code_reg),
        .operand(flag_src),
        .ccr_out(ccr_tested)
    );

    // Outputs straight from flip-flops
    assign mem_addr = addr_q;
    assign wr_out = wr_q;
    assign done = done_q;
    assign illegal = illegal_q;
    // Bytes move only in fetch states; read and transfer cycles refuse them
    assign byte_take = byte_valid && (in_opcode || state_q == ST_OFFSET); // [RULE3]
    // Operand strobe stands for the single read cycle
    assign mem_rd = (state_q == ST_READ); // [RULE2]

    // Sequencer: one state per bus cycle, stalls while no byte is offered
    always_comb begin
        state_d = state_q;
        kind_d = kind_q;
        addr_d = addr_q;
        done_d = 1'b0;
        illegal_d = 1'b0;
        unique case (state_q)
            ST_OPCODE, ST_PFX_OP: begin
                if (byte_valid) begin
                    kind_d = kind_now;
                    state_d = ST_OPCODE;
                    unique case (kind_now)
                        K_PREFIX: begin
                            state_d = ST_PFX_OP; // [RULE7]
                        end
                        K_TEST_DIR, K_TEST_IX1, K_TEST_SP1: begin
                            state_d = ST_OFFSET; // [RULE3]
                        end
                        K_TEST_IX: begin
                            addr_d = regs_in.index_pair; // [RULE2]
                            state_d = ST_READ;
                        end
                        K_TEST_ACCUM, K_TEST_INDEX_LOW, K_INDEX_LOW_TO_ACCUM: begin
                            done_d = 1'b1; // [RULE1] [RULE5]
                        end
                        K_SP_TO_INDEX_PAIR, K_INDEX_PAIR_TO_SP: begin
                            state_d = ST_XFER; // [RULE4] [RULE6]
                        end
                        K_ILLEGAL: begin
                            illegal_d = 1'b1;
                        end
                    endcase
                end
            end
            ST_OFFSET: begin
                if (byte_valid) begin
                    state_d = ST_READ;
                    unique case (kind_q)
                        K_TEST_DIR: addr_d = dir_addr; // [RULE3]
                        K_TEST_IX1: addr_d = ix1_addr; // [RULE3]
                        default: addr_d = sp1_addr; // [RULE3] [RULE7]
                    endcase
                end
            end
            ST_READ, ST_XFER: begin
                done_d = 1'b1; // [RULE2] [RULE4] [RULE6]
                state_d = ST_OPCODE;
            end
        endcase
    end

    // Write-back contents; at most one strobe per finishing cycle
    always_comb begin
        wr_d = '0;
        unique case (state_q)
            ST_OPCODE, ST_PFX_OP: begin
                if (op_fire && reg_test_now) begin
                    wr_d.ccr_we = 1'b1; // [RULE1]
                    wr_d.cond_code_reg = ccr_tested;
                end else if (op_fire && kind_now == K_INDEX_LOW_TO_ACCUM) begin
                    wr_d.accum_we = 1'b1; // [RULE5]
                    wr_d.accum = regs_in.index_pair[7:0];
                end
            end
            ST_OFFSET: begin
                wr_d = '0;
            end
            ST_READ: begin
                wr_d.ccr_we = 1'b1; // [RULE1] [RULE2]
                wr_d.cond_code_reg = ccr_tested;
            end
            ST_XFER: begin
                // Transfers never touch the flags
                if (kind_q == K_SP_TO_INDEX_PAIR) begin
                    wr_d.index_pair_we = 1'b1; // [RULE4]
                    wr_d.index_pair = sp_plus_one;
                end else begin
                    wr_d.stack_ptr_we = 1'b1; // [RULE6]
                    wr_d.stack_ptr = hx_minus_one;
                end
            end
        endcase
    end

    // State and address registers
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_q <= ST_OPCODE;
            kind_q <= K_ILLEGAL;
            addr_q <= ADDR_RESET;
        end else begin
            state_q <= state_d;
            kind_q <= kind_d;
            addr_q <= addr_d;
        end
    end

    // Write-back and status, registered so the core sees clean strobes
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            wr_q <= '0;
            done_q <= 1'b0;
            illegal_q <= 1'b0;
        end else begin
            wr_q <= wr_d;
            done_q <= done_d;
            illegal_q <= illegal_d;
        end
    end

endmodule

/* File: tao_pkg.sv */
package tao_pkg;

    // Opcodes of the unprefixed map
    localparam logic [7:0] OPC_TEST_DIR = 8'h3D;
    localparam logic [7:0] OPC_TEST_ACCUM = 8'h4D;
    localparam logic [7:0] OPC_TEST_INDEX_LOW = 8'h5D;
    localparam logic [7:0] OPC_TEST_IX1 = 8'h6D;
    localparam logic [7:0] OPC_TEST_IX = 8'h7D;
    localparam logic [7:0] OPC_INDEX_PAIR_TO_SP = 8'h94;
    localparam logic [7:0] OPC_SP_TO_INDEX_PAIR = 8'h95;
    localparam logic [7:0] OPC_INDEX_LOW_TO_ACCUM = 8'h9F;
    localparam logic [7:0] OPC_PREFIX = 8'h9E;

    // Opcode inside the prefixed map (stack offset form)
    localparam logic [7:0] OPC_PFX_TEST_SP1 = 8'h6D;

    // Condition code bit positions
    localparam int CCR_V_BIT = 7;
    localparam int CCR_H_BIT = 4;
    localparam int CCR_I_BIT = 3;
    localparam int CCR_N_BIT = 2;
    localparam int CCR_Z_BIT = 1;
    localparam int CCR_C_BIT = 0;

    // Reset address, zero byte and one word constants
    localparam logic [15:0] ADDR_RESET = 16'h0000;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [15:0] ONE_WORD = 16'h0001;

    // Instruction cycle counts, opcode fetch cycle included
    localparam int CYC_TEST_DIR = 3;
    localparam int CYC_TEST_REG = 1;
    localparam int CYC_TEST_IX1 = 3;
    localparam int CYC_TEST_IX = 2;
    localparam int CYC_TEST_SP1 = 4;
    localparam int CYC_SP_TO_INDEX_PAIR = 2;
    localparam int CYC_INDEX_LOW_TO_ACCUM = 1;
    localparam int CYC_INDEX_PAIR_TO_SP = 2;

    // Decoded instruction kind
    typedef enum logic [3:0] {
        K_TEST_DIR,
        K_TEST_IX1,
        K_TEST_SP1,
        K_TEST_IX,
        K_TEST_ACCUM,
        K_TEST_INDEX_LOW,
        K_SP_TO_INDEX_PAIR,
        K_INDEX_LOW_TO_ACCUM,
        K_INDEX_PAIR_TO_SP,
        K_PREFIX,
        K_ILLEGAL
    } tao_kind_t;

    // Current core register values
    typedef struct packed {
        logic [7:0] accum;
        logic [15:0] index_pair;
        logic [15:0] stack_ptr;
        logic [7:0] cond_code_reg;
    } tao_regs_t;

    // Register write-back toward the core
    typedef struct packed {
        logic accum_we;
        logic [7:0] accum;
        logic index_pair_we;
        logic [15:0] index_pair;
        logic stack_ptr_we;
        logic [15:0] stack_ptr;
        logic ccr_we;
        logic [7:0] cond_code_reg;
    } tao_wr_t;

endpackage

/* File: tao_flag_unit.sv */
`timescale 1ns/10ps
module tao_flag_unit import tao_pkg::*; (
    // Flags before the test
    input wire logic [7:0] ccr_in,
    // Value compared against zero
    input wire logic [7:0] operand,
    // Flags after the test
    output logic [7:0] ccr_out
);

    wire is_zero = (operand == ZERO_BYTE);

    // Only V, N and Z move; H, I and C pass through untouched
    always_comb begin
        ccr_out = ccr_in;
        ccr_out[CCR_V_BIT] = 1'b0; // [RULE1]
        ccr_out[CCR_N_BIT] = operand[7]; // [RULE1]
        ccr_out[CCR_Z_BIT] = is_zero; // [RULE1]
    end

endmodule

/* File: tao_checker.sv */
`timescale 1ns/10ps
module tao_checker import tao_pkg::*; (
    // Clock, reset, byte stream
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [7:0] byte_data,
    input wire logic byte_take,
    // Operand path, registers, status
    input wire logic mem_rd,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    input wire tao_regs_t regs_in,
    input wire tao_wr_t wr_out,
    input wire logic done,
    input wire logic illegal
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // Prefix then stack form; illegal guard stops a stray second prefix matching
    sequence s_pfx;
        byte_take && byte_data == OPC_PREFIX
        ##1 byte_take && !illegal && byte_data == OPC_PFX_TEST_SP1;
    endsequence
    sequence s_sp_read;
        mem_rd && mem_addr == $past(regs_in.stack_ptr) + {8'h00, $past(byte_data)};
    endsequence
    property p_sp1;
        s_pfx ##1 byte_take |=> s_sp_read ##1 done;
    endproperty
    a_sp1: assert property (p_sp1) else $error("stack form read");
    property p_rd_end;
        mem_rd |=> done && wr_out.ccr_we && !wr_out.accum_we && !wr_out.stack_ptr_we;
    endproperty
    a_rd_end: assert property (p_rd_end) else $error("read not ended");
    property p_nz;
        mem_rd |=> wr_out.cond_code_reg[2:1] == {$past(mem_rdata[7]), $past(mem_rdata) == 8'h00};
    endproperty
    a_nz: assert property (p_nz) else $error("test flags");
    property p_keep;
        wr_out.ccr_we |-> !wr_out.cond_code_reg[7]
            && wr_out.cond_code_reg[4:3] == $past(regs_in.cond_code_reg[4:3])
            && wr_out.cond_code_reg[0] == $past(regs_in.cond_code_reg[0]);
    endproperty
    a_keep: assert property (p_keep) else $error("kept flags");
    property p_tsx;
        wr_out.index_pair_we |-> done && !wr_out.ccr_we
            && wr_out.index_pair == $past(regs_in.stack_ptr) + 16'h0001;
    endproperty
    a_tsx: assert property (p_tsx) else $error("sp to pair");
    property p_txa;
        wr_out.accum_we |-> done && !wr_out.ccr_we
            && wr_out.accum == $past(regs_in.index_pair[7:0]);
    endproperty
    a_txa: assert property (p_txa) else $error("index low to accum");
    property p_txs;
        wr_out.stack_ptr_we |-> done && !wr_out.ccr_we
            && wr_out.stack_ptr == $past(regs_in.index_pair) - 16'h0001;
    endproperty
    a_txs: assert property (p_txs) else $error("pair to sp");
endmodule
bind tao_exec tao_checker u_chk (.sys_clk(sys_clk), .rstn(rstn), .byte_data(byte_data),
    .byte_take(byte_take), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .regs_in(regs_in), .wr_out(wr_out), .done(done), .illegal(illegal));

/* File: tb_test_and_transfer_ops.sv */
`timescale 1ns/10ps
module tb_test_and_transfer_ops import tao_pkg::*;;
    logic sys_clk, rstn, byte_valid, byte_take, mem_rd, done, illegal, tk, dn, il;
    logic [7:0] byte_data, mem_rdata, mv;
    logic [15:0] mem_addr, ad;
    tao_regs_t rg;
    tao_wr_t wr_out, wv;
    int cyc, err_count, total_checks;
    logic [7:0] ops [9] = '{8'h3D, 8'h4D, 8'h5D, 8'h6D, 8'h7D, 8'h94, 8'h95, 8'h9F, 8'h6D};

    always #10 sys_clk = ~sys_clk;
    // Inverted outside the read cycle so stale data never passes
    assign mem_rdata = mem_rd ? mv : ~mv;

    tao_exec u_dut (.sys_clk(sys_clk), .rstn(rstn), .byte_valid(byte_valid),
        .byte_data(byte_data), .byte_take(byte_take), .mem_rd(mem_rd), .mem_addr(mem_addr),
        .mem_rdata(mem_rdata), .regs_in(rg), .wr_out(wr_out), .done(done), .illegal(illegal));

    // Edge snapshot, read at the falling edge to stay clear of races
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        tk <= byte_valid && byte_take;
        dn <= done;
        il <= illegal;
        wv <= wr_out;
        if (mem_rd) ad <= mem_addr;
        if (cyc > 3000) begin
            err_count++;
            results();
        end
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic run(input logic [7:0] op, input logic pfx, input logic [7:0] ofs);
        logic [7:0] b[$];
        logic [7:0] v;
        logic [15:0] ea;
        logic bad;
        int t0;
        int k;
        int nc;
        tao_wr_t e;
        b = '{op};
        if (pfx) b.push_front(OPC_PREFIX);
        bad = pfx ? op != 8'h6D : !(op inside {8'h3D, 8'h4D, 8'h5D, 8'h6D, 8'h7D, 8'h94, 8'h95, 8'h9F});
        if (!bad && (pfx || op inside {8'h3D, 8'h6D})) b.push_back(ofs);
        v = op == 8'h4D ? rg.accum : op == 8'h5D ? rg.index_pair[7:0] : mv;
        ea = pfx ? rg.stack_ptr + ofs : op == 8'h3D ? {8'h00, ofs} : rg.index_pair + (op == 8'h6D ? ofs : 8'h00);
        nc = pfx ? 4 : op inside {8'h3D, 8'h6D} ? 3 : op == 8'h7D ? 2 : 1;
        e = '0;
        case (op)
            8'h95: begin
                {e.index_pair_we, e.index_pair} = {1'b1, rg.stack_ptr + 16'h0001};
                nc = 2;
            end
            8'h94: begin
                {e.stack_ptr_we, e.stack_ptr} = {1'b1, rg.index_pair - 16'h0001};
                nc = 2;
            end
            8'h9F: {e.accum_we, e.accum} = {1'b1, rg.index_pair[7:0]};
            default: e.cond_code_reg = {1'b0, rg.cond_code_reg[6:3], v[7], v == 8'h00, rg.cond_code_reg[0]};
        endcase
        e.ccr_we = !(op inside {8'h94, 8'h95, 8'h9F});
        foreach (b[i]) begin
            byte_valid = 1'b1;
            byte_data = b[i];
            k = 0;
            do begin
                @(negedge sys_clk);
                k++;
            end while (!tk && k < 20);
            if (i == 0) t0 = cyc;
        end
        byte_valid = 1'b0;
        for (k = 0; !dn && !il && k < 20; k++) @(negedge sys_clk);
        chk(il, bad);
        if (!bad) begin
            chk(cyc - t0, nc);
            chk(wv, e);
            if (pfx || op inside {8'h3D, 8'h6D, 8'h7D}) chk(ad, ea);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        {sys_clk, rstn, byte_valid, byte_data, rg, mv} = '0;
        void'($urandom(15038));
        repeat (8) @(negedge sys_clk);
        rstn = 1'b1;
        @(negedge sys_clk);
        for (int n = 0; n < 36; n++) begin
            rg = 40'({$urandom, $urandom});
            mv = 8'($urandom);
            run(ops[n % 9], n % 9 == 8, 8'($urandom));
        end
        $display("random opcode test done");
        // Sums wrapping at 16 bits, zero and negative operands
        rg = {8'h00, 16'h0000, 16'hFFFF, 8'hFF};
        foreach (ops[i]) run(ops[i], i == 8, 8'h01);
        mv = 8'h80;
        run(8'h7D, 1'b0, 8'h00);
        $display("boundary test done");
        // Unknown opcode, bad prefixed opcode, prefix twice
        run(8'h00, 1'b0, 8'h00);
        run(8'h4D, 1'b1, 8'h00);
        run(OPC_PREFIX, 1'b1, 8'h00);
        $display("illegal opcode test done");
        results();
    end
endmodule
